// >>> src/a4w_area4_sram_wait_timing.sv
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
// Operation
// - bits 31..21 and 15..13 of the wait register always read zero
// - reserved bit 19 of the wait register always reads zero
// - byte strobe scheme applies only in byte-selection sram mode
// - scheme 0: byte strobes at strobe timing, direction low whole write cycle
// - scheme 1: byte strobes whole access cycle, direction low at write timing
// - write wait code 000 reuses the read wait count
// - write wait codes 001..111 insert 0..6 wait cycles
// - setup codes delay strobe 0.5, 1.5, 2.5, 3.5 cycles after select
// - scheme, write wait and setup fields reset to zero, read and write
// - read wait codes give 0..6, 8, 10, 12, 14, 18, 24 cycles
module a4w_area4_sram_wait_timing
  import a4w_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [A4W_ADDR_W-1:0] mem_addr,
  output logic area_select_n,
  output logic read_strobe_n,
  output logic [3:0] byte_write_n,
  output logic read_write,
  output logic [31:0] mem_data_out,
  output logic mem_data_oe,
  input wire logic [31:0] mem_data_in
);
  // bus slave and register state
  logic aw_held, w_held, bvalid, rvalid, start;
  logic next_aw_held, next_w_held, next_bvalid, next_rvalid, next_start;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data, rdata, next_rdata;
  logic [3:0] w_strb, next_w_strb;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic byte_strobe_scheme_select, next_bas, byte_sram, next_byte_sram, cmd_write, next_cmd_write;
  logic [2:0] write_wait, next_write_wait;
  logic [1:0] setup_code, next_setup_code;
  logic [3:0] read_wait, next_read_wait, cmd_be, next_cmd_be;
  logic [A4W_ADDR_W-1:0] cmd_addr, next_cmd_addr;
  logic [31:0] cmd_wdata, next_cmd_wdata, read_data, next_read_data;
  logic [31:0] wait_control_view, reg_view;
  logic reg_hit;
  logic [7:0] rd_addr;
  // memory sequencer state
  a4w_state_type state, next_state;
  logic [5:0] count, next_count;
  logic [31:0] data_meta, data_sync;
  logic busy;

  assign busy = (state != A4W_IDLE);
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  // reserved bits are never stored, so they read back as zero
  always_comb
  begin
    wait_control_view = 32'h0;
    wait_control_view[A4W_BAS_BIT] = byte_strobe_scheme_select;
    wait_control_view[A4W_WW_MSB:A4W_WW_LSB] = write_wait;
    wait_control_view[A4W_SW_MSB:A4W_SW_LSB] = setup_code;
    wait_control_view[A4W_WR_MSB:A4W_WR_LSB] = read_wait;
  end

  // read mux shared by the read channel
  always_comb
  begin
    rd_addr = s_axi_araddr;
    reg_view = 32'h0;
    reg_hit = 1'b1;
    case (rd_addr)
      A4W_WAIT_CONTROL_OFS: reg_view = wait_control_view;
      A4W_MODE_OFS: reg_view[A4W_MODE_BYTE_SRAM_BIT] = byte_sram;
      A4W_ADDR_OFS: reg_view[A4W_ADDR_W-1:0] = cmd_addr;
      A4W_WDATA_OFS: reg_view = cmd_wdata;
      A4W_COMMAND_OFS:
      begin
        reg_view[A4W_CMD_WRITE_BIT] = cmd_write;
        reg_view[A4W_CMD_BE_MSB:A4W_CMD_BE_LSB] = cmd_be;
        reg_view[A4W_CMD_BUSY_BIT] = busy;
      end
      A4W_RDATA_OFS: reg_view = read_data;
      default: reg_hit = 1'b0;
    endcase
  end

  // axi4-lite slave: address and data taken in either order, answer after both
  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_start = 1'b0;
    next_bas = byte_strobe_scheme_select;
    next_write_wait = write_wait;
    next_setup_code = setup_code;
    next_read_wait = read_wait;
    next_byte_sram = byte_sram;
    next_cmd_addr = cmd_addr;
    next_cmd_wdata = cmd_wdata;
    next_cmd_write = cmd_write;
    next_cmd_be = cmd_be;
    next_read_data = read_data;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (aw_held && w_held)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = A4W_RESP_OKAY;
      // strobes gate each field by its byte lane
      case (aw_addr)
        A4W_WAIT_CONTROL_OFS:
        begin
          if (w_strb[2])
          begin
            next_bas = w_data[A4W_BAS_BIT];
            next_write_wait = w_data[A4W_WW_MSB:A4W_WW_LSB];
          end
          if (w_strb[1])
            next_setup_code = w_data[A4W_SW_MSB:A4W_SW_LSB];
          if (w_strb[1] && w_strb[0])
            next_read_wait = w_data[A4W_WR_MSB:A4W_WR_LSB];
        end
        A4W_MODE_OFS:
          if (w_strb[0])
            next_byte_sram = w_data[A4W_MODE_BYTE_SRAM_BIT];
        A4W_ADDR_OFS:
        begin
          if (w_strb[0])
            next_cmd_addr[7:0] = w_data[7:0];
          if (w_strb[1])
            next_cmd_addr[15:8] = w_data[15:8];
        end
        A4W_WDATA_OFS:
          for (int i = 0; i < 4; i++)
            if (w_strb[i])
              next_cmd_wdata[i*8 +: 8] = w_data[i*8 +: 8];
        A4W_COMMAND_OFS:
          // a command written while busy is dropped; software polls busy first
          if (w_strb[0] && !busy)
          begin
            next_cmd_write = w_data[A4W_CMD_WRITE_BIT];
            next_cmd_be = w_data[A4W_CMD_BE_MSB:A4W_CMD_BE_LSB];
            next_start = w_data[A4W_CMD_START_BIT];
          end
        A4W_RDATA_OFS: next_bresp = A4W_RESP_OKAY;
        default: next_bresp = A4W_RESP_SLVERR;
      endcase
    end
    if (bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rdata = reg_view;
      next_rresp = reg_hit ? A4W_RESP_OKAY : A4W_RESP_SLVERR;
    end
    else if (rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    // read data captured from the pins at the end of the hold phase
    if (state == A4W_HOLD && !cmd_write)
      next_read_data = data_sync;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= A4W_RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= A4W_RESP_OKAY;
      start <= 1'b0;
      byte_strobe_scheme_select <= 1'b0;
      write_wait <= 3'h0;
      setup_code <= 2'h0;
      read_wait <= A4W_WR_RESET;
      byte_sram <= 1'b0;
      cmd_addr <= '0;
      cmd_wdata <= 32'h0;
      cmd_write <= 1'b0;
      cmd_be <= 4'h0;
      read_data <= 32'h0;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      start <= next_start;
      byte_strobe_scheme_select <= next_bas;
      write_wait <= next_write_wait;
      setup_code <= next_setup_code;
      read_wait <= next_read_wait;
      byte_sram <= next_byte_sram;
      cmd_addr <= next_cmd_addr;
      cmd_wdata <= next_cmd_wdata;
      cmd_write <= next_cmd_write;
      cmd_be <= next_cmd_be;
      read_data <= next_read_data;
    end
  end

  // sequencer: setup is 2*code+1 half cycles, strobe is one cycle plus the waits
  always_comb
  begin
    logic [4:0] waits;
    waits = a4w_read_wait(read_wait);
    if (cmd_write && write_wait != 3'h0)
      waits = {2'h0, write_wait - 3'h1};
    else
      waits = a4w_read_wait(read_wait);
    next_state = state;
    next_count = count;
    case (state)
      A4W_IDLE:
        if (start)
        begin
          next_state = A4W_SETUP;
          next_count = {3'h0, setup_code, 1'b0};
        end
      A4W_SETUP:
        if (count == 6'h00)
        begin
          next_state = A4W_STROBE;
          next_count = 6'(({1'b0, waits} + 6'h01) * A4W_HALF_PER_CYCLE) - A4W_ONE_HALF;
        end
        else
          next_count = count - 6'h01;
      A4W_STROBE:
        if (count == 6'h00)
          next_state = A4W_HOLD;
        else
          next_count = count - 6'h01;
      A4W_HOLD: next_state = A4W_IDLE;
      default: next_state = A4W_IDLE;
    endcase
  end

  // pin outputs registered from the next state so they change on one edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= A4W_IDLE;
      count <= 6'h00;
      data_meta <= 32'h0;
      data_sync <= 32'h0;
      mem_addr <= '0;
      area_select_n <= 1'b1;
      read_strobe_n <= 1'b1;
      byte_write_n <= 4'hf;
      read_write <= 1'b1;
      mem_data_out <= 32'h0;
      mem_data_oe <= 1'b0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      data_meta <= mem_data_in;
      data_sync <= data_meta;
      mem_addr <= cmd_addr;
      mem_data_out <= cmd_wdata;
      area_select_n <= (next_state == A4W_IDLE);
      mem_data_oe <= cmd_write && (next_state != A4W_IDLE);
      read_strobe_n <= !(!cmd_write && next_state == A4W_STROBE);
      if (!byte_sram)
      begin
        byte_write_n <= ~(cmd_be & {4{cmd_write && next_state == A4W_STROBE}});
        read_write <= !(cmd_write && next_state != A4W_IDLE);
      end
      else if (!byte_strobe_scheme_select)
      begin
        byte_write_n <= ~(cmd_be & {4{next_state == A4W_STROBE}});
        read_write <= !(cmd_write && next_state != A4W_IDLE);
      end
      else
      begin
        byte_write_n <= ~(cmd_be & {4{next_state != A4W_IDLE}});
        read_write <= !(cmd_write && next_state == A4W_STROBE);
      end
    end
  end
endmodule : a4w_area4_sram_wait_timing

// >>> src/a4w_pkg.sv
package a4w_pkg;
  // register byte offsets on the axi4-lite bus
  localparam logic [7:0] A4W_WAIT_CONTROL_OFS = 8'h00;
  localparam logic [7:0] A4W_MODE_OFS = 8'h04;
  localparam logic [7:0] A4W_ADDR_OFS = 8'h08;
  localparam logic [7:0] A4W_WDATA_OFS = 8'h0c;
  localparam logic [7:0] A4W_COMMAND_OFS = 8'h10;
  localparam logic [7:0] A4W_RDATA_OFS = 8'h14;

  // area4_wait_control field positions
  localparam int A4W_BAS_BIT = 20;
  localparam int A4W_WW_LSB = 16;
  localparam int A4W_WW_MSB = 18;
  localparam int A4W_SW_LSB = 11;
  localparam int A4W_SW_MSB = 12;
  localparam int A4W_WR_LSB = 7;
  localparam int A4W_WR_MSB = 10;
  localparam logic [3:0] A4W_WR_RESET = 4'ha;

  // command register fields
  localparam int A4W_CMD_START_BIT = 0;
  localparam int A4W_CMD_WRITE_BIT = 1;
  localparam int A4W_CMD_BE_LSB = 4;
  localparam int A4W_CMD_BE_MSB = 7;
  localparam int A4W_CMD_BUSY_BIT = 8;
  localparam int A4W_MODE_BYTE_SRAM_BIT = 0;

  localparam int A4W_ADDR_W = 16;
  localparam logic [1:0] A4W_RESP_OKAY = 2'h0;
  localparam logic [1:0] A4W_RESP_SLVERR = 2'h2;

  // one bus cycle is two aclk periods, so half cycles are whole aclk periods
  localparam logic [5:0] A4W_HALF_PER_CYCLE = 6'h02;
  localparam logic [5:0] A4W_ONE_HALF = 6'h01;

  typedef enum logic [1:0] {A4W_IDLE, A4W_SETUP, A4W_STROBE, A4W_HOLD} a4w_state_type;

  // read wait code to bus cycles; prohibited codes fall back to the longest
  function automatic logic [4:0] a4w_read_wait(input logic [3:0] code);
    logic [4:0] cycles;
    cycles = 5'h18;
    case (code)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: cycles = {1'b0, code};
      4'h7: cycles = 5'h08;
      4'h8: cycles = 5'h0a;
      4'h9: cycles = 5'h0c;
      4'ha: cycles = 5'h0e;
      4'hb: cycles = 5'h12;
      default: cycles = 5'h18;
    endcase
    return cycles;
  endfunction : a4w_read_wait
endpackage : a4w_pkg

// >>> sim/a4w_timing_asserts.sv
`timescale 1ns/1ps
// protocol and pin timing checks, seen only from the block's ports
module a4w_timing_asserts
  import a4w_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic area_select_n,
  input wire logic read_strobe_n,
  input wire logic [3:0] byte_write_n
);
  logic [7:0] ar_q;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // last read address taken, so read data can be tied to its register
  always_ff @(posedge aclk)
  begin
    if (s_axi_arvalid && s_axi_arready)
      ar_q <= s_axi_araddr;
  end
  AST_BV_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_RV_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_AR_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_RESV: assert property (s_axi_rvalid && ar_q == A4W_WAIT_CONTROL_OFS |-> (s_axi_rdata & 32'hffe8e000) == 32'h0)
    else $error("reserved wait bits read nonzero");
  AST_SETUP: assert property ($fell(area_select_n) |-> read_strobe_n)
    else $error("strobe with select, no setup");
  AST_STROBE_SEL: assert property (!read_strobe_n |-> !area_select_n)
    else $error("strobe outside select");
  AST_HOLD: assert property ($rose(area_select_n) |-> read_strobe_n && byte_write_n == 4'hf)
    else $error("strobe still low at select release");
endmodule : a4w_timing_asserts

// >>> sim/a4w_sram_model.sv
`timescale 1ns/1ps
// static memory at the far side; data lines go stale once select and hold pass
module a4w_sram_model
  import a4w_pkg::*;
(
  input wire logic aclk,
  input wire logic [A4W_ADDR_W-1:0] mem_addr,
  input wire logic area_select_n,
  input wire logic [3:0] byte_write_n,
  input wire logic read_write,
  input wire logic [31:0] mem_data_out,
  input wire logic mem_data_oe,
  output logic [31:0] mem_data_in
);
  logic [31:0] mem [0:255];
  int hold = 0;
  initial mem_data_in = 32'h0;
  // lanes stored only while strobed with direction low; released bus toggles
  always @(posedge aclk)
  begin
    for (int i = 0; i < 4; i++)
      if (!byte_write_n[i] && !read_write && mem_data_oe)
        mem[mem_addr[7:0]][8*i+:8] <= mem_data_out[8*i+:8];
    hold <= area_select_n ? (hold > 0 ? hold - 1 : 0) : 3;
    if (!area_select_n && read_write)
      mem_data_in <= mem[mem_addr[7:0]];
    else if (area_select_n && hold == 0)
      mem_data_in <= ~mem_data_in;
  end
endmodule : a4w_sram_model

// >>> sim/test_area4_sram_wait_timing.sv
`timescale 1ns/1ps
module test_area4_sram_wait_timing;
  import a4w_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, mem_data_out, mem_data_in;
  logic [3:0] s_axi_wstrb = 4'hf, byte_write_n;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [A4W_ADDR_W-1:0] mem_addr;
  logic area_select_n, read_strobe_n, read_write, mem_data_oe;
  int bad_count = 0, checks = 0, sel_n = 0, rs_n = 0, bw_n = 0, rw_n = 0;
  int rtab [16] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24, 24, 24, 24};
  logic [31:0] mm [logic [7:0]];
  a4w_area4_sram_wait_timing i_a4w_area4_sram_wait_timing (.*);
  a4w_sram_model i_a4w_sram_model (.*);
  initial forever #4 aclk = ~aclk;
  // pin activity per access, cleared before each command
  always @(posedge aclk)
  begin
    sel_n += !area_select_n;
    rs_n += !read_strobe_n;
    bw_n += (byte_write_n != 4'hf);
    rw_n += !read_write;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic close_out;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  // each channel released at the edge it is taken; bready held until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 200);
    s_axi_bready <= 1'b0;
    // a response that never came counts against the run
    cmp({31'h0, s_axi_bvalid}, 32'h1);
    cmp(s_axi_bresp, er);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 200);
    s_axi_rready <= 1'b0;
    cmp({31'h0, s_axi_rvalid}, 32'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
  // one memory access, pin counts predicted from the wait settings
  task automatic acc(input logic [31:0] c, input logic md, input logic w, input logic [3:0] be,
    input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic [1:0] r;
    int t, s, k;
    k = (w && c[18:16] != 3'h0) ? c[18:16] - 1 : rtab[c[10:7]];
    // strobe spans whole bus cycles of two clocks; one clock of hold stays under select
    t = 2 * k + 2;
    s = 2 * c[12:11] + 1 + t + 1;
    wr(A4W_WAIT_CONTROL_OFS, c, A4W_RESP_OKAY);
    rd(A4W_WAIT_CONTROL_OFS, q, r);
    cmp(q, c);
    cmp(r, A4W_RESP_OKAY);
    wr(A4W_MODE_OFS, {31'h0, md}, A4W_RESP_OKAY);
    wr(A4W_ADDR_OFS, {24'h0, a}, A4W_RESP_OKAY);
    wr(A4W_WDATA_OFS, d, A4W_RESP_OKAY);
    sel_n = 0;
    rs_n = 0;
    bw_n = 0;
    rw_n = 0;
    wr(A4W_COMMAND_OFS, {24'h0, be, 2'h0, w, 1'b1}, A4W_RESP_OKAY);
    q = 32'h100;
    for (int i = 0; i < 60 && q[8] !== 1'b0; i++)
      rd(A4W_COMMAND_OFS, q, r);
    // an access that never finished counts against the run
    cmp({31'h0, q[8]}, 32'h0);
    cmp(sel_n, s);
    cmp(rs_n, w ? 0 : t);
    cmp(bw_n, (md && c[20]) ? s : (md || w) ? t : 0);
    cmp(rw_n, w ? ((md && c[20]) ? t : s) : 0);
    for (int i = 0; i < 4; i++)
      if (w && be[i])
        mm[a][8*i+:8] = d[8*i+:8];
    if (!w)
    begin
      rd(A4W_RDATA_OFS, q, r);
      cmp(q, mm[a]);
    end
  endtask : acc
  // watchdog: 25000 clocks, several times the longest expected run
  initial
  begin
    #200000;
    bad_count++;
    close_out();
  end
  initial
  begin
    logic [31:0] q, c;
    logic [1:0] r;
    void'($urandom(32'h4f1e0897));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A4W_WAIT_CONTROL_OFS, q, r);
    cmp(q, 32'h500);
    // ones into reserved places on purpose, to see them read back as zero
    wr(A4W_WAIT_CONTROL_OFS, 32'hffffffff, A4W_RESP_OKAY);
    rd(A4W_WAIT_CONTROL_OFS, q, r);
    cmp(q, 32'h00171f80);
    wr(8'h40, 32'h1, A4W_RESP_SLVERR);
    rd(8'h40, q, r);
    cmp(r, A4W_RESP_SLVERR);
    cmp(q, 32'h0);
    for (int n = 0; n < 24; n++)
    begin
      c = {11'h0, 1'($urandom), 1'b0, 3'($urandom), 3'h0, 2'($urandom), 4'($urandom % 13), 7'h0};
      acc(c, 1'($urandom), 1'b1, n < 8 ? 4'hf : 4'($urandom % 15 + 1), 8'(n % 8), $urandom);
      acc(c, 1'($urandom), 1'b0, 4'($urandom % 15 + 1), 8'(n % 8), 32'h0);
    end
    close_out();
  end
endmodule : test_area4_sram_wait_timing
bind a4w_area4_sram_wait_timing a4w_timing_asserts i_a4w_timing_asserts (.*);
